// ===== common/fpt_params.svh
`ifndef FPT_PARAMS_SVH
`define FPT_PARAMS_SVH

// register offsets (word addresses on the plain port)
`define FPT_OFS_CFG 4'h0
`define FPT_OFS_TALLY 4'h4

// configuration field positions
`define FPT_CFG_DUTY_LSB 0
`define FPT_CFG_RATE_LSB 8
`define FPT_CFG_INVERT_BIT 11
`define FPT_CFG_DRAIN_BIT 12
`define FPT_CFG_GATE_BIT 13
`define FPT_CFG_MODE_BIT 14
`define FPT_CFG_RESET 32'h0000_0000

// timing
`define FPT_CLK_HZ 40000000
`define FPT_GATE_DELAY_NS 10000
`define FPT_CLK_PERIOD_NS 25
`define FPT_GATE_DELAY_CYC ((`FPT_GATE_DELAY_NS + `FPT_CLK_PERIOD_NS - 1) / `FPT_CLK_PERIOD_NS)
`define FPT_SECOND_CYC `FPT_CLK_HZ

// pwm rates in hz, one per select code
`define FPT_RATE_0 10
`define FPT_RATE_1 20
`define FPT_RATE_2 40
`define FPT_RATE_3 60
`define FPT_RATE_4 80
`define FPT_RATE_5 100
`define FPT_RATE_6 120
`define FPT_RATE_7 25000

`endif

// ===== common/fpt_pkg.sv
package fpt_pkg;
	typedef logic [2:0] fpt_rate_t;
	typedef logic [7:0] fpt_duty_t;
	typedef logic [15:0] fpt_tally_t;
	typedef enum logic [2:0] {
		FPT_GATE_SHUT = 3'b001,
		FPT_GATE_WAIT = 3'b010,
		FPT_GATE_OPEN = 3'b100
	} fpt_gate_e;
endpackage

// ===== rtl/fpt_pwm_gen.sv
`timescale 1ns/10ps
`include "fpt_params.svh"

// pwm waveform: 256 slots per period, high while slot < duty, or in every slot at duty 0xFF
module fpt_pwm_gen #(
	parameter int CLK_HZ = `FPT_CLK_HZ
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire fpt_pkg::fpt_rate_t rate_sel,
	input wire fpt_pkg::fpt_duty_t duty,
	output logic pwm_high
);
	import fpt_pkg::*;

	// clock cycles per slot for a given rate code
	function automatic logic [31:0] slot_len(input fpt_rate_t r);
		int hz;
		case (r)
			3'h0: hz = `FPT_RATE_0;
			3'h1: hz = `FPT_RATE_1;
			3'h2: hz = `FPT_RATE_2;
			3'h3: hz = `FPT_RATE_3;
			3'h4: hz = `FPT_RATE_4;
			3'h5: hz = `FPT_RATE_5;
			3'h6: hz = `FPT_RATE_6;
			default: hz = `FPT_RATE_7;
		endcase
		slot_len = 32'(CLK_HZ / (hz * 256));
	endfunction

	logic [31:0] pre_q;
	logic [7:0] slot_q;

	// prescaler and slot counter; rate change applies to the slot already in progress
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pre_q <= 32'h0000_0000;
			slot_q <= 8'h00;
		end else if (pre_q + 32'h0000_0001 >= slot_len(rate_sel)) begin
			pre_q <= 32'h0000_0000;
			slot_q <= slot_q + 8'h01;
		end else begin
			pre_q <= pre_q + 32'h0000_0001;
		end
	end

	// duty 0xFF means full on, so 0..100% are both reachable
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pwm_high <= 1'b0;
		end else begin
			pwm_high <= (duty == 8'hFF) || (slot_q < duty);
		end
	end
endmodule

// ===== rtl/fpt_fan_ctrl.sv
`timescale 1ns/10ps
`include "fpt_params.svh"

// Contract
// - pwm rate selectable: 10,20,40,60,80,100,120 Hz or 25 kHz
// - pwm high time from 8-bit duty, 0% through 100%
// - invert flips pin level; 100% then gives constant low
// - drain-only drive: data held 0, enable carries waveform
// - 16-bit counter increments on each tach rising edge
// - mode 1: readable count is wrapping total since reset
// - mode 0: readable count loaded each second with last second
// - gated counting counts only during uninverted pwm high phase
// - gate opens 10 us after pwm rise, closes at once on fall
module fpt_fan_ctrl #(
	parameter int SECOND_CYC = `FPT_SECOND_CYC,
	parameter int GATE_CYC = `FPT_GATE_DELAY_CYC
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic speed_sense_in,
	output logic pwm_out,
	output logic pwm_oe
);
	import fpt_pkg::*;

	logic [31:0] cfg_q;
	fpt_duty_t duty;
	fpt_rate_t pulse_rate_select;
	logic output_invert;
	logic drain_only_drive_on;
	logic gated_counting_on;
	logic total_mode;
	logic pwm_high;

	assign duty = cfg_q[`FPT_CFG_DUTY_LSB +: 8];
	assign pulse_rate_select = cfg_q[`FPT_CFG_RATE_LSB +: 3];
	assign output_invert = cfg_q[`FPT_CFG_INVERT_BIT];
	assign drain_only_drive_on = cfg_q[`FPT_CFG_DRAIN_BIT];
	assign gated_counting_on = cfg_q[`FPT_CFG_GATE_BIT];
	assign total_mode = cfg_q[`FPT_CFG_MODE_BIT];

	// configuration register write; unused bits stored as zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			cfg_q <= `FPT_CFG_RESET;
		end else if (reg_wr && reg_addr == `FPT_OFS_CFG) begin
			cfg_q <= reg_wdata & 32'h0000_7FFF;
		end
	end

	fpt_pwm_gen #(
		.CLK_HZ(`FPT_CLK_HZ)
	) u_pwm (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.rate_sel(pulse_rate_select),
		.duty(duty),
		.pwm_high(pwm_high)
	);

	// pin drive; pin_level_q is the polarity-corrected waveform
	logic pin_level_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pin_level_q <= 1'b0;
		end else begin
			pin_level_q <= pwm_high ^ output_invert;
		end
	end
	// drain-only: pin data stays low, enable pulls the wire down
	assign pwm_out = drain_only_drive_on ? 1'b0 : pin_level_q;
	assign pwm_oe = drain_only_drive_on ? ~pin_level_q : 1'b1;

	// tach synchroniser; first stage read only by the second
	logic sense_meta_q;
	logic sense_sync_q;
	logic sense_prev_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			sense_meta_q <= 1'b0;
			sense_sync_q <= 1'b0;
			sense_prev_q <= 1'b0;
		end else begin
			sense_meta_q <= speed_sense_in;
			sense_sync_q <= sense_meta_q;
			sense_prev_q <= sense_sync_q;
		end
	end

	// gate: delay after pwm rise masks tach glitches from switching
	fpt_gate_e gate_q;
	logic [31:0] gate_cnt_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			gate_q <= FPT_GATE_SHUT;
			gate_cnt_q <= 32'h0000_0000;
		end else begin
			case (gate_q)
				FPT_GATE_SHUT: begin
					gate_cnt_q <= 32'h0000_0000;
					if (pwm_high) begin
						gate_q <= FPT_GATE_WAIT;
					end
				end
				FPT_GATE_WAIT: begin
					if (!pwm_high) begin
						gate_q <= FPT_GATE_SHUT;
					end else if (gate_cnt_q + 32'h0000_0001 >= 32'(GATE_CYC)) begin
						gate_q <= FPT_GATE_OPEN;
					end else begin
						gate_cnt_q <= gate_cnt_q + 32'h0000_0001;
					end
				end
				FPT_GATE_OPEN: begin
					if (!pwm_high) begin
						gate_q <= FPT_GATE_SHUT;
					end
				end
				default: gate_q <= FPT_GATE_SHUT;
			endcase
		end
	end

	logic tach_edge;
	// count only in the open gate when gating is on
	assign tach_edge = sense_sync_q && !sense_prev_q &&
		(!gated_counting_on || gate_q == FPT_GATE_OPEN);

	// one-second tick from the system clock
	logic [31:0] sec_cnt_q;
	logic sec_tick;
	assign sec_tick = (sec_cnt_q + 32'h0000_0001 >= 32'(SECOND_CYC));
	always_ff @(posedge sys_clk) begin
		if (sys_rst || sec_tick) begin
			sec_cnt_q <= 32'h0000_0000;
		end else begin
			sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
		end
	end

	// running counters: total wraps, window restarts each second
	fpt_tally_t total_q;
	fpt_tally_t window_q;
	fpt_tally_t snap_q;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			total_q <= 16'h0000;
		end else if (tach_edge) begin
			total_q <= total_q + 16'h0001;
		end
	end
	// an edge in the tick cycle belongs to the closing second
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			window_q <= 16'h0000;
			snap_q <= 16'h0000;
		end else if (sec_tick) begin
			window_q <= 16'h0000;
			snap_q <= window_q + (tach_edge ? 16'h0001 : 16'h0000);
		end else if (tach_edge) begin
			window_q <= window_q + 16'h0001;
		end
	end

	fpt_tally_t rotation_tally;
	assign rotation_tally = total_mode ? total_q : snap_q;

	// read data valid the cycle after the strobe; unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd && reg_addr == `FPT_OFS_CFG) begin
			reg_rdata <= cfg_q;
		end else if (reg_rd && reg_addr == `FPT_OFS_TALLY) begin
			reg_rdata <= {16'h0000, rotation_tally};
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end
endmodule

// ===== tb/fpt_fan_monitor.sv
`timescale 1ns/10ps
module fpt_fan_monitor (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic pwm_out,
	input wire logic pwm_oe
);
	logic [14:0] cfg_q;
	// shadow of config as software wrote it
	always_ff @(posedge sys_clk) begin
		if (sys_rst)
			cfg_q <= 15'h0;
		else if (reg_wr && reg_addr == 4'h0)
			cfg_q <= reg_wdata[14:0];
	end
	default clocking mcb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);
	chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("rdata not idle");
	chk_cfg_back: assert property (
		reg_rd && reg_addr == 4'h0 |=> reg_rdata == {17'h0, cfg_q})
		else $error("config readback");
	chk_tally_wide: assert property (
		reg_rd && reg_addr == 4'h4 |=> reg_rdata[31:16] == 16'h0)
		else $error("tally upper bits");
	chk_unmapped_zero: assert property (reg_rd && reg_addr != 4'h0
		&& reg_addr != 4'h4 |=> reg_rdata == 32'h0)
		else $error("unmapped read");
	chk_drain_data: assert property (cfg_q[12] |-> !pwm_out)
		else $error("drain data high");
	chk_push_oe: assert property (!cfg_q[12] |-> pwm_oe)
		else $error("push enable low");
	// level passes two register stages, so config must stand two cycles
	chk_full_duty: assert property (
		cfg_q[7:0] == 8'hFF && $past(cfg_q) == cfg_q
		&& $past(cfg_q, 2) == cfg_q && !cfg_q[12]
		|-> pwm_out == !cfg_q[11]) else $error("full duty level");
	chk_zero_duty: assert property (
		cfg_q[7:0] == 8'h00 && $past(cfg_q) == cfg_q
		&& $past(cfg_q, 2) == cfg_q && !cfg_q[12]
		|-> pwm_out == cfg_q[11]) else $error("zero duty level");
endmodule
bind fpt_fan_ctrl fpt_fan_monitor mon (.sys_clk(sys_clk),
	.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.pwm_out(pwm_out), .pwm_oe(pwm_oe));

// ===== tb/fpt_fan_model.sv
`timescale 1ns/10ps
// fan tach pulses, unrelated in phase to the system clock
module fpt_fan_model (
	input wire logic run,
	input wire logic [31:0] half_ns,
	output logic speed_sense_in,
	output int rises
);
	// a started pulse always completes, so no runt edges
	initial begin
		speed_sense_in = 1'b0;
		rises = 0;
		forever begin
			wait (run);
			#(half_ns) speed_sense_in = 1'b1;
			rises++;
			#(half_ns) speed_sense_in = 1'b0;
		end
	end
endmodule

// ===== tb/fpt_fan_ctrl_tb_top.sv
`timescale 1ns/10ps
module fpt_fan_ctrl_tb_top;
	logic sys_clk, sys_rst, reg_wr, reg_rd, pwm_out, pwm_oe, run, tach;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rv, t0, half_ns;
	int num_errors, total_checks, seed, rises, n, cyc, hi, lo;
	fpt_fan_ctrl #(.SECOND_CYC(1000), .GATE_CYC(10)) dut (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .speed_sense_in(tach),
		.pwm_out(pwm_out), .pwm_oe(pwm_oe));
	fpt_fan_model fan (.run(run), .half_ns(half_ns),
		.speed_sense_in(tach), .rises(rises));
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task automatic check(input string nm, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic end_sim;
		if (num_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// hang guard, about four times the planned run
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			end_sim();
		end
	end
	function automatic logic [31:0] cfg(logic [7:0] d, logic [2:0] r,
		logic [3:0] f);
		return {17'h0, f, r, d};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(posedge sys_clk);
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
		@(posedge sys_clk);
	endtask
	task automatic delta(input string nm, input logic [31:0] e);
		rd(4'h4);
		check(nm, {16'h0, rv[15:0] - t0[15:0]}, e);
	endtask
	task automatic spin(input int c, input logic [31:0] h);
		half_ns = h;
		n = rises;
		run = 1'b1;
		wait (rises == n + c);
		run = 1'b0;
		#(h + 150);
		@(posedge sys_clk);
	endtask
	// cycles until the pin leaves level v
	task automatic lvl(input logic v, output int c);
		c = 0;
		do begin
			@(posedge sys_clk);
			#1 c++;
		end while (pwm_out === v && c < 2000);
	endtask
	initial begin
		seed = 32'hB51D;
		{sys_rst, reg_wr, reg_rd, run} = 4'b1000;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		half_ns = 32'd100;
		repeat (10) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		rd(4'h4);
		check("tally rst", rv, 32'h0);
		for (int i = 0; i < 8; i++) begin
			t0 = $random(seed);
			t0[10:8] = i[2:0];
			wr(4'h0, t0);
			rd(4'h0);
			check("cfg", rv, {17'h0, t0[14:0]});
		end
		wr(4'h8, 32'hFFFF_FFFF);
		rd(4'h8);
		check("unmapped", rv, 32'h0);
		// forced levels in each polarity and drive mode
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, cfg(i[0] ? 8'hFF : 8'h00, 3'h7, {2'b00, i[2:1]}));
			// duty and level are two register stages behind the config
			repeat (2) @(posedge sys_clk);
			#1 check("pin", {pwm_out, pwm_oe}, i[2] ?
				{1'b0, !(i[0] ^ i[1])} : {i[0] ^ i[1], 1'b1});
		end
		// free total, random pulse count
		wr(4'h0, cfg(8'h40, 3'h7, 4'h8));
		rd(4'h4);
		t0 = rv;
		hi = 4 + $unsigned($random(seed)) % 28;
		spin(hi, 60 + $unsigned($random(seed)) % 100);
		delta("total", hi);
		// gate shut at 0%, open at 100%, invert must not matter
		for (int i = 0; i < 4; i++) begin
			wr(4'h0, cfg(i[0] ? 8'hFF : 8'h00, 3'h7, {3'b110, i[1]}));
			repeat (20) @(posedge sys_clk);
			rd(4'h4);
			t0 = rv;
			spin(12, 150);
			delta("gated", i[0] ? 12 : 0);
		end
		// early pulse after a rise is dropped, later one counted
		wr(4'h0, cfg(8'd8 + $unsigned($random(seed)) % 240, 3'h7, 4'hC));
		rd(4'h4);
		t0 = rv;
		lvl(1'b1, lo);
		lvl(1'b0, lo);
		spin(1, 40);
		repeat (20) @(posedge sys_clk);
		spin(1, 40);
		delta("gate delay", 1);
		// finish this high phase, then time one low and one high phase
		lvl(1'b1, hi);
		lvl(1'b0, lo);
		lvl(1'b1, hi);
		check("high", hi, 6 * reg_wdata[7:0]);
		check("period", hi + lo, 1536);
		// per-second snapshot: 20-cycle tach period, 1000-cycle second
		wr(4'h0, cfg(8'h40, 3'h7, 4'h0));
		half_ns = 32'd250;
		run = 1'b1;
		repeat (2500) @(posedge sys_clk);
		rd(4'h4);
		check("second", rv >= 49 && rv <= 51, 1);
		run = 1'b0;
		repeat (2100) @(posedge sys_clk);
		rd(4'h4);
		check("idle second", rv, 0);
		end_sim();
	end
endmodule
